// ### hdl/touch_ctrl_host_register_bank.sv
// host-visible control register bank of the touch controller
// assumes a decoded byte register port; wr/rd strobes are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module touch_ctrl_host_register_bank
    import touch_regs_pkg::*;
#(
    parameter int PINS = 8
) (
    // clock and reset
    input  wire logic            clk,
    input  wire logic            rst,
    // register port
    input  wire logic            reg_wr,
    input  wire logic            reg_rd,
    input  wire logic [7:0]      reg_addr,
    input  wire logic [7:0]      reg_wdata,
    output logic [7:0]           reg_rdata,
    // configuration from parameter memory
    input  wire logic [PINS-1:0] output_powerup_state,
    input  wire logic [PINS-1:0] output_pin_enabled,
    input  wire logic [7:0]      lit_level,
    input  wire logic [7:0]      dark_level,
    input  wire logic            autolight_on,
    // sensing engine
    input  wire logic            comp_done,
    input  wire logic            mode_entered,
    input  wire logic            irq_clear,
    output logic                 comp_start,
    output logic [1:0]           op_mode,
    output logic                 interrupt_out_n,
    // lighting
    output logic [PINS*8-1:0]    pin_level,
    // parameter memory gateway
    output logic                 gw_enable,
    output logic                 gw_read,
    output logic [7:0]           gw_base,
    output logic                 gw_wr,
    output logic                 gw_rd,
    output logic [2:0]           gw_offset,
    output logic [7:0]           gw_wdata,
    input  wire logic [7:0]      gw_rdata,
    output logic                 burn_start,
    output logic                 chip_reset
);
    // ************************************************************
    // register state
    // ************************************************************
    logic [1:0]        mode_q, mode_d;
    logic              comp_q, comp_d, comp_start_q, comp_start_d;
    logic [PINS-1:0]   out_ctrl_q, out_ctrl_d;
    logic [2:0]        sel_q, sel_d;
    logic [7:0]        level_q [PINS], level_d [PINS];
    logic [1:0]        gw_en_q, gw_en_d;
    logic              gw_dir_q, gw_dir_d;
    logic [7:0]        base_q, base_d;
    logic              armed_q, armed_d, chip_rst_q, chip_rst_d;
    burn_state_t       burn_q, burn_d;
    logic              burn_go_q, burn_go_d;
    logic              irq_q, irq_d;
    logic              irq_n_q, irq_n_d, gw_on_q, gw_on_d;
    logic [7:0]        rdata_q, rdata_d;
    logic              gw_wr_q, gw_rd_q;
    logic [2:0]        gw_off_q;
    logic [7:0]        gw_wdata_q;
    logic              init_q;
    logic              gw_hit;

    // gateway window only covers 0..7 while enabled
    assign gw_hit = (gw_en_q == GW_EN_ON) && (reg_addr <= ADDR_GW_LAST);

    // ************************************************************
    // next-state logic
    // ************************************************************
    always_comb begin
        mode_d       = mode_q;
        comp_d       = comp_q;
        comp_start_d = 1'b0;
        out_ctrl_d   = out_ctrl_q;
        sel_d        = sel_q;
        level_d      = level_q;
        gw_en_d      = gw_en_q;
        gw_dir_d     = gw_dir_q;
        base_d       = base_q;
        armed_d      = armed_q;
        chip_rst_d   = 1'b0;
        burn_d       = burn_q;
        burn_go_d    = 1'b0;
        irq_d        = irq_q;
        rdata_d      = rdata_q;
        // power-up state loads once after reset release
        if (!init_q) begin
            out_ctrl_d = output_powerup_state;
            for (int i = 0; i < PINS; i++) begin
                level_d[i] = output_powerup_state[i] ? lit_level : dark_level;
            end
        end
        // completion clears the busy bit; a write cannot restart it
        if (comp_q && comp_done) begin
            comp_d = 1'b0;
        end
        // interrupt set wins over clear
        if (irq_clear) begin
            irq_d = 1'b0;
        end
        if (mode_entered) begin
            irq_d = 1'b1;
        end
        if (reg_wr && !gw_hit) begin
            case (reg_addr)
                ADDR_COMP_MODE: begin
                    mode_d = reg_wdata[1:0];
                    if (reg_wdata[COMP_BIT] && !comp_q) begin
                        comp_d       = 1'b1;
                        comp_start_d = 1'b1;
                    end
                end
                ADDR_OUT_CTRL:   out_ctrl_d = reg_wdata[PINS-1:0];
                ADDR_PIN_SEL:    sel_d = reg_wdata[2:0];
                ADDR_PIN_INT:    level_d[sel_q] = reg_wdata;
                ADDR_GW_CFG: begin
                    gw_en_d  = reg_wdata[5:4];
                    gw_dir_d = reg_wdata[GW_DIR_BIT];
                end
                ADDR_GW_BASE: begin
                    // burn sequence steals the base register writes
                    if (burn_q == BURN_KEY2 && reg_wdata == BURN_GO_1) begin
                        burn_d = BURN_GO1;
                    end else if (burn_q == BURN_GO1 && reg_wdata == BURN_GO_2) begin
                        burn_d    = BURN_IDLE;
                        burn_go_d = 1'b1;
                    end else begin
                        base_d = reg_wdata & ~GW_BASE_ALIGN;
                        burn_d = BURN_IDLE;
                    end
                end
                ADDR_KEY_HIGH: burn_d = (reg_wdata == BURN_KEY_HI) ? BURN_KEY1 : BURN_IDLE;
                ADDR_KEY_LOW: begin
                    burn_d = (burn_q == BURN_KEY1 && reg_wdata == BURN_KEY_LO)
                             ? BURN_KEY2 : BURN_IDLE;
                end
                ADDR_SOFT_RESET: begin
                    if (armed_q && reg_wdata == RST_FIRE_KEY) begin
                        chip_rst_d = 1'b1;
                        armed_d    = 1'b0;
                    end else begin
                        armed_d = (reg_wdata == RST_ARM_KEY);
                    end
                end
                default: ;
            endcase
        end
        // read data is registered; write-only registers read as zero
        if (reg_rd) begin
            if (gw_hit) begin
                rdata_d = gw_rdata;
            end else begin
                case (reg_addr)
                    ADDR_COMP_MODE: rdata_d = {5'h0, comp_q, mode_q};
                    ADDR_OUT_CTRL:  rdata_d = 8'(out_ctrl_q);
                    ADDR_PIN_SEL:   rdata_d = {5'h0, sel_q};
                    ADDR_PIN_INT:   rdata_d = level_q[sel_q];
                    ADDR_GW_CFG:    rdata_d = {2'h0, gw_en_q, gw_dir_q, 3'h0};
                    ADDR_GW_BASE:   rdata_d = base_q;
                    default:        rdata_d = 8'h00;
                endcase
            end
        end
        // pin-facing flags get flops of their own so no gate sits after them
        irq_n_d = ~irq_d;
        gw_on_d = (gw_en_d == GW_EN_ON);
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_q       <= MODE_ACTIVE;
            comp_q       <= 1'b0;
            comp_start_q <= 1'b0;
            out_ctrl_q   <= '0;
            sel_q        <= 3'h0;
            for (int i = 0; i < PINS; i++) begin
                level_q[i] <= 8'h00;
            end
            gw_en_q      <= 2'h0;
            gw_dir_q     <= 1'b0;
            base_q       <= GW_BASE_RESET;
            armed_q      <= 1'b0;
            chip_rst_q   <= 1'b0;
            burn_q       <= BURN_IDLE;
            burn_go_q    <= 1'b0;
            irq_q        <= 1'b0;
            irq_n_q      <= 1'b1;
            gw_on_q      <= 1'b0;
            rdata_q      <= 8'h00;
            init_q       <= 1'b0;
        end else begin
            mode_q       <= mode_d;
            comp_q       <= comp_d;
            comp_start_q <= comp_start_d;
            out_ctrl_q   <= out_ctrl_d;
            sel_q        <= sel_d;
            level_q      <= level_d;
            gw_en_q      <= gw_en_d;
            gw_dir_q     <= gw_dir_d;
            base_q       <= base_d;
            armed_q      <= armed_d;
            chip_rst_q   <= chip_rst_d;
            burn_q       <= burn_d;
            burn_go_q    <= burn_go_d;
            irq_q        <= irq_d;
            irq_n_q      <= irq_n_d;
            gw_on_q      <= gw_on_d;
            rdata_q      <= rdata_d;
            init_q       <= 1'b1;
        end
    end

    // ************************************************************
    // gateway byte strobes, registered
    // ************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gw_wr_q    <= 1'b0;
            gw_rd_q    <= 1'b0;
            gw_off_q   <= 3'h0;
            gw_wdata_q <= 8'h00;
        end else begin
            gw_wr_q    <= reg_wr && gw_hit && !gw_dir_q;
            gw_rd_q    <= reg_rd && gw_hit && gw_dir_q;
            gw_off_q   <= reg_addr[2:0];
            gw_wdata_q <= reg_wdata;
        end
    end

    // ************************************************************
    // pin levels: one flop per pin; disabled pins hold zero
    // ************************************************************
    for (genvar p = 0; p < PINS; p++) begin : g_pin
        logic [7:0] lvl_q;
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                lvl_q <= 8'h00;
            end else if (!output_pin_enabled[p]) begin
                lvl_q <= 8'h00;
            end else if (!autolight_on) begin
                lvl_q <= out_ctrl_q[p] ? lit_level : dark_level;
            end
        end
        assign pin_level[p*8 +: 8] = lvl_q;
        // each output pin follows its control bit while autolight is off; other pins stay at zero
        pin_follow_a: assert property (@(posedge clk) disable iff (rst)
            output_pin_enabled[p] && !autolight_on
            |=> lvl_q == ($past(out_ctrl_q[p]) ? $past(lit_level) : $past(dark_level)))
            else $error("pin level wrong");
        pin_dark_a: assert property (@(posedge clk) disable iff (rst)
            !output_pin_enabled[p] |=> lvl_q == 8'h00) else $error("disabled pin lit");
    end

    // outputs straight from flops
    assign reg_rdata       = rdata_q;
    assign comp_start      = comp_start_q;
    assign op_mode         = mode_q;
    assign interrupt_out_n = irq_n_q;
    assign gw_enable       = gw_on_q;
    assign gw_read         = gw_dir_q;
    assign gw_base         = base_q;
    assign gw_wr           = gw_wr_q;
    assign gw_rd           = gw_rd_q;
    assign gw_offset       = gw_off_q;
    assign gw_wdata        = gw_wdata_q;
    assign burn_start      = burn_go_q;
    assign chip_reset      = chip_rst_q;

    // ************************************************************
    // checks
    // ************************************************************
    comp_start_a: assert property (@(posedge clk) disable iff (rst)
        reg_wr && !gw_hit && reg_addr == ADDR_COMP_MODE && reg_wdata[COMP_BIT] && !comp_q
        |=> comp_start && comp_q) else $error("compensation not started");
    comp_norestart_a: assert property (@(posedge clk) disable iff (rst)
        comp_q |=> !comp_start) else $error("compensation restarted");
    mode_write_a: assert property (@(posedge clk) disable iff (rst)
        reg_wr && !gw_hit && reg_addr == ADDR_COMP_MODE
        |=> op_mode == $past(reg_wdata[1:0])) else $error("mode not taken");
    soft_reset_a: assert property (@(posedge clk) disable iff (rst)
        chip_reset |-> $past(armed_q) && $past(reg_wdata) == RST_FIRE_KEY)
        else $error("reset without arm");
    disarm_a: assert property (@(posedge clk) disable iff (rst)
        armed_q && reg_wr && reg_addr == ADDR_SOFT_RESET && reg_wdata != RST_FIRE_KEY
        && reg_wdata != RST_ARM_KEY |=> !armed_q && !chip_reset)
        else $error("bad key kept arm");
    burn_seq_a: assert property (@(posedge clk) disable iff (rst)
        burn_start |-> $past(burn_q) == BURN_GO1) else $error("burn out of order");
    irq_set_a: assert property (@(posedge clk) disable iff (rst)
        mode_entered |=> !interrupt_out_n) else $error("mode irq lost");
    base_align_a: assert property (@(posedge clk) disable iff (rst)
        gw_base[2:0] == 3'h0) else $error("base not aligned");
    sel_read_a: assert property (@(posedge clk) disable iff (rst)
        reg_rd && !gw_hit && reg_addr == ADDR_PIN_INT
        |=> reg_rdata == $past(level_q[sel_q])) else $error("intensity readback");
    cov_comp_c: cover property (@(posedge clk) comp_start ##[1:20] !comp_q);
    cov_reset_c: cover property (@(posedge clk) chip_reset);
    cov_burn_c: cover property (@(posedge clk) burn_start);
    cov_gw_c: cover property (@(posedge clk) gw_wr ##[1:50] gw_rd);
endmodule
`default_nettype wire

// ### shared/touch_regs_pkg.sv
// register map, field layout and reset values of the host register bank
// assumes a byte-wide register port decoded by the serial slave in front of it
// Summary of operation
// - compensation bit reads 1 while running, 0 when done; writing 1 starts a run
// - mode bits 1:0: 00 active (reset), 01 doze, 10 sleep, 11 reserved
// - host writes zeros to upper five mode bits; device may return anything
// - output-control bit 1 drives lit level, 0 dark level, when autolight off
// - output-control resets from power-up state; non-output pin bits have no effect
// - pin selector bits 2:0 choose pwm pin for intensity access; resets to 0
// - intensity write sets selected pin index; read returns selected pin index
// - each pin index resets to lit or dark level per power-up state
// - writing 0xDE then 0x00 to soft-reset register resets the chip
// - gateway config bits 5:4: 01 enables gateway, 00 disables, 10/11 reserved
// - gateway config bit 3 picks direction: 0 write memory, 1 read memory
// - every gateway exchange moves exactly eight bytes from the aligned base; the bank strobes one byte per window access and does not count them
// - burn unlock needs 0x62 in key-high; other values do not unlock
// - burn unlock also needs 0x9D in key-low
// - gateway bytes live at addresses 0..7; writing 000 to bits 5:3 closes
// - entering active or doze sets mode flag and asserts interrupt output
// - after keys, writing 0xA5 then 0x5A to base starts the burn
package touch_regs_pkg;
    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [7:0] ADDR_COMP_MODE   = 8'h09;
    localparam logic [7:0] ADDR_OUT_CTRL    = 8'h0a;
    localparam logic [7:0] ADDR_PIN_SEL     = 8'h0b;
    localparam logic [7:0] ADDR_PIN_INT     = 8'h0c;
    localparam logic [7:0] ADDR_GW_CFG      = 8'h0d;
    localparam logic [7:0] ADDR_GW_BASE     = 8'h0e;
    localparam logic [7:0] ADDR_KEY_HIGH    = 8'hac;
    localparam logic [7:0] ADDR_KEY_LOW     = 8'had;
    localparam logic [7:0] ADDR_SOFT_RESET  = 8'hb1;
    localparam logic [7:0] ADDR_GW_LAST     = 8'h07;
    // ************************************************************
    // fields, keys and reset values
    // ************************************************************
    localparam int         COMP_BIT         = 2;
    localparam int         GW_DIR_BIT       = 3;
    localparam logic [1:0] GW_EN_ON         = 2'h1;
    localparam logic [7:0] RST_ARM_KEY      = 8'hde;
    localparam logic [7:0] RST_FIRE_KEY     = 8'h00;
    localparam logic [7:0] BURN_KEY_HI      = 8'h62;
    localparam logic [7:0] BURN_KEY_LO      = 8'h9d;
    localparam logic [7:0] BURN_GO_1        = 8'ha5;
    localparam logic [7:0] BURN_GO_2        = 8'h5a;
    localparam logic [7:0] GW_BASE_RESET    = 8'h00;
    localparam logic [7:0] GW_BASE_ALIGN    = 8'h07;
    // ************************************************************
    // operating modes and burn unlock states
    // ************************************************************
    typedef enum logic [1:0] {
        MODE_ACTIVE = 2'b00,
        MODE_DOZE   = 2'b01,
        MODE_SLEEP  = 2'b10,
        MODE_RSVD   = 2'b11
    } op_mode_t;
    typedef enum logic [2:0] {
        BURN_IDLE  = 3'b000,
        BURN_KEY1  = 3'b001,
        BURN_KEY2  = 3'b010,
        BURN_GO1   = 3'b011
    } burn_state_t;
endpackage

// ### verification/host_port_model.sv
// host side of the register port: single byte writes and reads
// assumes one caller at a time and a register bank sampling on rising clk
`timescale 1ns/1ps
`default_nettype none
module host_port_model
    import touch_regs_pkg::*;
(
    // clock
    input  wire logic       clk,
    // register port
    output logic            reg_wr,
    output logic            reg_rd,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    // ****************************************
    // idle bus and transfer tasks
    // ****************************************
    // idle levels before the first request
    initial begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 8'hff;
        reg_wdata = 8'hff;
    end
    // released address and data flip so nothing stale looks valid
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        logic [7:0] d;
        d = data;
        if (addr == ADDR_COMP_MODE || addr == ADDR_PIN_SEL) d = data & 8'h07;
        if (addr == ADDR_GW_CFG) d = data & 8'h38;
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= addr;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~addr;
        reg_wdata <= ~d;
    endtask
    // read data is registered, so it is taken one edge after the strobe
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= addr;
        @(posedge clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~addr;
        @(posedge clk);
        data = reg_rdata;
    endtask
endmodule
`default_nettype wire

// ### verification/tb_touch_ctrl_host_register_bank.sv
// self-checking bench for the host register bank
// assumes the host model drives the register port, the bench the engine side
`timescale 1ns/1ps
`default_nettype none
module tb_touch_ctrl_host_register_bank
    import touch_regs_pkg::*;
;
    // ****************************************
    // signals
    // ****************************************
    logic        clk = 0, rst = 1, comp_done = 0, mode_entered = 0, irq_clear = 0;
    logic        autolight_on = 0, reg_wr, reg_rd, comp_start, interrupt_out_n;
    logic        gw_enable, gw_read, gw_wr, gw_rd, burn_start, chip_reset;
    logic [1:0]  op_mode;
    logic [2:0]  gw_offset;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, lit_level, dark_level, gw_base;
    logic [7:0]  gw_wdata, gw_rdata = 0, output_powerup_state, output_pin_enabled;
    logic [7:0]  rd_q, oc, d[8];
    logic [63:0] pin_level;
    int          fail_count = 0, total_checks = 0, n_comp = 0, n_rst = 0;
    int          n_burn = 0, n_gwrd = 0, lvl[8];
    logic [10:0] gw_q[$];
    // 200 MHz clock
    always #2.5 clk = ~clk;
    touch_ctrl_host_register_bank #(.PINS(8)) u_touch_ctrl_host_register_bank (.*);
    host_port_model u_host_port_model (.*);
    // ****************************************
    // monitors and helpers
    // ****************************************
    // pulses are tallied at the edge after their launch
    always @(posedge clk) begin
        if (comp_start === 1'b1) n_comp++;
        if (chip_reset === 1'b1) n_rst++;
        if (burn_start === 1'b1) n_burn++;
        if (gw_rd === 1'b1) n_gwrd++;
        if (gw_wr === 1'b1) gw_q.push_back({gw_offset, gw_wdata});
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        u_host_port_model.read_reg(a, rd_q);
        chk(rd_q, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        u_host_port_model.write_reg(a, v);
    endtask
    // engine pulse: 0 compensation done, 1 mode entered, 2 flag cleared
    task automatic engine(input int k);
        @(posedge clk);
        {comp_done, mode_entered, irq_clear} <= 3'h4 >> k;
        @(posedge clk);
        {comp_done, mode_entered, irq_clear} <= 3'h0;
    endtask
    // expected lighting: output pins follow the control bit, others stay dark at 0
    function automatic logic [63:0] exp_lvl();
        logic [63:0] v;
        v = '0;
        for (int p = 0; p < 8; p++) if (output_pin_enabled[p]) v[8*p +: 8] = oc[p] ? lit_level : dark_level;
        return v;
    endfunction
    task automatic wait_irq();
        int i;
        for (i = 0; i < 10 && interrupt_out_n !== 1'b0; i++) @(posedge clk);
        chk(i < 10, 1);
        if (i == 10) wrap_up();
        engine(2);
        repeat (2) @(posedge clk);
        chk(interrupt_out_n, 1);
    endtask
    task automatic wrap_up();
        $display("checks=%0d failures=%0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        chk(0, 1);
        wrap_up();
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        void'($urandom(32'hae07));
        output_powerup_state = $urandom;
        output_pin_enabled = $urandom;
        lit_level = $urandom;
        dark_level = $urandom;
        oc = output_powerup_state;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        // reset state
        rd(ADDR_COMP_MODE, 8'h00);
        chk(op_mode, 0);
        rd(ADDR_GW_CFG, 8'h00);
        rd(ADDR_GW_BASE, GW_BASE_RESET);
        rd(ADDR_OUT_CTRL, oc);
        chk(pin_level, exp_lvl());
        rd(ADDR_PIN_SEL, 8'h00);
        rd(8'h05, 8'h00);
        // every pin index: reset value, then new value with both extremes
        for (int p = 0; p < 8; p++) begin
            wr(ADDR_PIN_SEL, 8'(p));
            rd(ADDR_PIN_INT, oc[p] ? lit_level : dark_level);
            lvl[p] = (p == 0) ? 0 : (p == 7) ? 255 : $urandom_range(255);
            wr(ADDR_PIN_INT, 8'(lvl[p]));
        end
        for (int p = 7; p >= 0; p--) begin
            wr(ADDR_PIN_SEL, 8'(p));
            rd(ADDR_PIN_INT, 8'(lvl[p]));
        end
        oc = $urandom;
        wr(ADDR_OUT_CTRL, oc);
        repeat (2) @(posedge clk);
        chk(pin_level, exp_lvl());
        rd(ADDR_OUT_CTRL, oc);
        // autolight on freezes the pins; they catch up once it is off again
        autolight_on <= 1'b1;
        wr(ADDR_OUT_CTRL, ~oc);
        repeat (2) @(posedge clk);
        chk(pin_level, exp_lvl());
        autolight_on <= 1'b0;
        oc = ~oc;
        repeat (2) @(posedge clk);
        chk(pin_level, exp_lvl());
        // compensation, second trigger while busy
        wr(ADDR_COMP_MODE, 8'h04);
        wr(ADDR_COMP_MODE, 8'h04);
        rd(ADDR_COMP_MODE, 8'h04);
        chk(n_comp, 1);
        engine(0);
        rd(ADDR_COMP_MODE, 8'h00);
        // modes, waiting for the mode interrupt in doze and active before reading back
        for (int m = 2; m >= 0; m--) begin
            wr(ADDR_COMP_MODE, 8'(m));
            if (m != 2) begin
                engine(1);
                wait_irq();
            end
            rd(ADDR_COMP_MODE, 8'(m));
            chk(op_mode, m);
        end
        // gateway write burst at the aligned base 0x78
        wr(ADDR_GW_CFG, 8'h10);
        wr(ADDR_GW_BASE, 8'h78);
        for (int i = 0; i < 8; i++) begin
            d[i] = $urandom;
            wr(8'(i), d[i]);
        end
        repeat (2) @(posedge clk);
        chk({gw_enable, gw_read, gw_base}, {2'h2, 8'h78});
        chk(gw_q.size(), 8);
        for (int i = 0; i < 8; i++) chk(gw_q.pop_front(), {3'(i), d[i]});
        // gateway read burst
        wr(ADDR_GW_CFG, 8'h18);
        for (int i = 0; i < 8; i++) begin
            gw_rdata <= d[7-i];
            rd(8'(i), d[7-i]);
        end
        repeat (2) @(posedge clk);
        chk({gw_read, 4'(n_gwrd), 4'(gw_q.size())}, {1'h1, 4'h8, 4'h0});
        wr(ADDR_GW_CFG, 8'h00);
        wr(8'h02, 8'hff);
        repeat (2) @(posedge clk);
        chk({gw_enable, 4'(gw_q.size())}, 0);
        // burn: wrong high key first, then the full key sequence
        for (int k = 0; k < 2; k++) begin
            wr(ADDR_GW_BASE, 8'h40);
            wr(ADDR_KEY_HIGH, k ? BURN_KEY_HI : 8'h63);
            wr(ADDR_KEY_LOW, BURN_KEY_LO);
            wr(ADDR_GW_BASE, BURN_GO_1);
            wr(ADDR_GW_BASE, BURN_GO_2);
            repeat (2) @(posedge clk);
            chk(n_burn, k);
        end
        chk(gw_base, 8'h40);
        rd(ADDR_KEY_HIGH, 8'h00);
        // soft reset: broken pair, then a pair with another write between
        wr(ADDR_SOFT_RESET, RST_ARM_KEY);
        wr(ADDR_SOFT_RESET, 8'h01);
        wr(ADDR_SOFT_RESET, RST_FIRE_KEY);
        repeat (2) @(posedge clk);
        chk(n_rst, 0);
        wr(ADDR_SOFT_RESET, RST_ARM_KEY);
        wr(ADDR_PIN_SEL, 8'h00);
        wr(ADDR_SOFT_RESET, RST_FIRE_KEY);
        repeat (2) @(posedge clk);
        chk(n_rst, 1);
        wrap_up();
    end
endmodule
`default_nettype wire
